// File: hdl/sbid_regs.vh
`ifndef SBID_REGS_VH
`define SBID_REGS_VH
// register offsets
`define SBID_OFS_RETRY_SRC   10'h000
`define SBID_OFS_ROM_ADDR    10'h001
`define SBID_OFS_ID_HI       10'h002
`define SBID_OFS_ID_MID      10'h003
`define SBID_OFS_ID_LO_CFG   10'h004
`define SBID_OFS_CFG_LO      10'h005
`define SBID_OFS_LAST        10'h005
// field positions
`define SBID_RETRY_MSB       7
`define SBID_RETRY_LSB       3
`define SBID_OTP_DIS_BIT     1
`define SBID_ROM_DIS_BIT     0
`define SBID_WIDE_BIT        7
// reset values
`define SBID_RETRY_RST       5'h01
`define SBID_REV_RST         4'h0
`endif

// File: hdl/sbid_retry_ctr.v
`timescale 1ns/1ps
// counts arbitration attempts; first attempt is free
module sbid_retry_ctr (
  input  wire       mclk,
  input  wire       reset,
  input  wire       start,
  input  wire       arb_lost,
  input  wire [4:0] limit,
  output reg        give_up
);
  reg [4:0] retries_r;
  always @(posedge mclk) begin
    if (reset || start) begin
      retries_r <= 5'h00;
      give_up   <= 1'b0;
    end else if (arb_lost) begin
      if (retries_r == limit) begin
        give_up <= 1'b1;
      end else begin
        retries_r <= retries_r + 5'h01;
      end
    end
  end
endmodule

// File: hdl/sbid_shadow_mem.v
`timescale 1ns/1ps
// eight-byte register store at the default AW of 3, registered read data
module sbid_shadow_mem #(
  parameter AW = 3
) (
  input  wire          mclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  input  wire [AW-1:0] raddr,
  output reg  [7:0]    rdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: hdl/sbid_top.v
`timescale 1ns/1ps
`include "sbid_regs.vh"
// How it works
// - five-bit retry limit for boot arbitration, read/write, resets to one.
// - first arbitration attempt is not counted; attempts equal limit plus one.
// - active-low boot source bits; serial memory values overwrite one-time values.
// - wide offset bit selects 15-bit multi-page boot memory offsets.
// - seven-bit field is the boot memory's two-wire bus address.
// - eleven-bit config code split over two bytes.
// - software may overwrite the config code once boot is done and read it back.
// - during boot load, serial control accesses are ignored.
// - on nack or checksum error, abort, leave registers not yet loaded at defaults, flag boot failure.
module sbid_top #(
  parameter [15:0] PART_ID_RST  = 16'h1234, // arbitrary value
  parameter [10:0] CFG_CODE_RST = 11'h000,
  parameter [6:0]  ROM_ADDR_RST = 7'h50,
  parameter        OTP_DIS_RST  = 1'b0,
  parameter        ROM_DIS_RST  = 1'b1,
  parameter        WIDE_RST     = 1'b0
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [9:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  input  wire       boot_wr,
  input  wire [9:0] boot_addr,
  input  wire [7:0] boot_wdata,
  input  wire       boot_arb_start,
  input  wire       boot_arb_lost,
  input  wire       boot_nack,
  input  wire       boot_crc_bad,
  input  wire       boot_done,
  output reg        boot_busy,
  output reg        boot_give_up,
  output reg        boot_load_failure,
  output reg  [4:0] arb_retry_limit,
  output reg        otp_load_disable_n,
  output reg        serial_rom_load_disable_n,
  output reg        wide_offset_select,
  output reg  [6:0] boot_rom_bus_address
);
  localparam ST_INIT = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [2:0] init_r;
  reg  [2:0] init_nxt;
  reg        rd_pend_r;
  reg        rd_map_r;
  reg  [7:0] init_byte;
  reg  [7:0] wd_mask;
  reg  [9:0] wa;
  reg  [7:0] wd_raw;
  wire [7:0] wd;
  wire [7:0] mem_rdata;
  wire       give_up;
  wire       in_init;
  wire       in_load;
  wire       in_run;
  wire       init_last;
  wire       in_map;
  wire       boot_in_map;
  wire       load_abort;
  wire       load_wr;
  wire       sw_wr;
  wire       wr;
  wire       hit_retry_src;
  wire       hit_rom_addr;

  assign in_init     = (state_r == ST_INIT);
  assign in_load     = (state_r == ST_LOAD);
  assign in_run      = (state_r == ST_RUN);
  assign init_last   = ({7'h00, init_r} == `SBID_OFS_LAST);
  assign in_map      = (reg_addr <= `SBID_OFS_LAST);
  assign boot_in_map = (boot_addr <= `SBID_OFS_LAST);
  assign load_abort  = in_load && (boot_nack || boot_crc_bad || give_up);

  // defaults are written into the store one byte per cycle after reset,
  // since a memory cannot be reset in one edge
  always @* begin
    init_byte = 8'h00;
    case (init_r)
      3'h0: begin
        init_byte = {`SBID_RETRY_RST, 1'b0, OTP_DIS_RST, ROM_DIS_RST};
      end
      3'h1: begin
        init_byte = {WIDE_RST, ROM_ADDR_RST};
      end
      3'h2: begin
        init_byte = {`SBID_REV_RST, PART_ID_RST[15:12]};
      end
      3'h3: begin
        init_byte = PART_ID_RST[11:4];
      end
      3'h4: begin
        init_byte = {PART_ID_RST[3:0], CFG_CODE_RST[10:7]};
      end
      3'h5: begin
        init_byte = {CFG_CODE_RST[6:0], 1'b0};
      end
      default: begin
        init_byte = 8'h00;
      end
    endcase
  end

  // reserved bit 2 of byte 0 and bit 0 of byte 5 stored as zero
  always @* begin
    wd_mask = 8'hFF;
    case (wa)
      `SBID_OFS_RETRY_SRC: begin
        wd_mask = 8'hFB;
      end
      `SBID_OFS_CFG_LO: begin
        wd_mask = 8'hFE;
      end
      default: begin
        wd_mask = 8'hFF;
      end
    endcase
  end

  // serial memory writes land after the otp defaults, so they overwrite them
  assign load_wr = in_load && boot_wr && boot_in_map;
  assign sw_wr   = in_run && reg_wr && in_map;
  assign wr      = in_init || load_wr || sw_wr;

  always @* begin
    wa     = reg_addr;
    wd_raw = reg_wdata;
    if (in_init) begin
      wa     = {7'h00, init_r};
      wd_raw = init_byte;
    end else if (load_wr) begin
      wa     = boot_addr;
      wd_raw = boot_wdata;
    end
  end

  assign wd            = wd_raw & wd_mask;
  assign hit_retry_src = wr && (wa == `SBID_OFS_RETRY_SRC);
  assign hit_rom_addr  = wr && (wa == `SBID_OFS_ROM_ADDR);

  sbid_shadow_mem #(
    .AW(3)
  ) u_mem (
    .mclk  (mclk),
    .we    (wr),
    .waddr (wa[2:0]),
    .wdata (wd),
    .raddr (reg_addr[2:0]),
    .rdata (mem_rdata)
  );

  sbid_retry_ctr u_rty (
    .mclk     (mclk),
    .reset    (reset),
    .start    (boot_arb_start),
    .arb_lost (boot_arb_lost),
    .limit    (arb_retry_limit),
    .give_up  (give_up)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: begin
        if (init_last) begin
          if (serial_rom_load_disable_n) begin
            state_nxt = ST_RUN;
          end else begin
            state_nxt = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (boot_done || load_abort) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always @* begin
    init_nxt = init_r;
    if (in_init) begin
      init_nxt = init_r + 3'h1;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_INIT;
      init_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      init_r  <= init_nxt;
    end
  end

  // busy follows the next state, so it drops in the edge that enters run
  // and the first access is taken at the edge after
  always @(posedge mclk) begin
    if (reset) begin
      boot_busy <= 1'b1;
    end else begin
      boot_busy <= (state_nxt != ST_RUN);
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      boot_give_up <= 1'b0;
    end else begin
      boot_give_up <= give_up;
    end
  end

  // sticky until reset; registers not yet loaded keep their defaults
  always @(posedge mclk) begin
    if (reset) begin
      boot_load_failure <= 1'b0;
    end else if (load_abort) begin
      boot_load_failure <= 1'b1;
    end
  end

  // control copies track every store write, so the pins match the store once init has rewritten bytes 0 and 1
  always @(posedge mclk) begin
    if (reset) begin
      arb_retry_limit <= `SBID_RETRY_RST;
    end else if (hit_retry_src) begin
      arb_retry_limit <= wd[`SBID_RETRY_MSB:`SBID_RETRY_LSB];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      otp_load_disable_n <= OTP_DIS_RST;
    end else if (hit_retry_src) begin
      otp_load_disable_n <= wd[`SBID_OTP_DIS_BIT];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      serial_rom_load_disable_n <= ROM_DIS_RST;
    end else if (hit_retry_src) begin
      serial_rom_load_disable_n <= wd[`SBID_ROM_DIS_BIT];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      wide_offset_select <= WIDE_RST;
    end else if (hit_rom_addr) begin
      wide_offset_select <= wd[`SBID_WIDE_BIT];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      boot_rom_bus_address <= ROM_ADDR_RST;
    end else if (hit_rom_addr) begin
      boot_rom_bus_address <= wd[6:0];
    end
  end

  // reads ignored while loading; the map check travels with the request,
  // so back-to-back reads to different offsets are masked correctly
  always @(posedge mclk) begin
    if (reset) begin
      rd_pend_r <= 1'b0;
      rd_map_r  <= 1'b0;
    end else begin
      rd_pend_r <= reg_rd && in_run;
      rd_map_r  <= in_map;
    end
  end

  // registered store gives one cycle of latency before the answer
  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_r;
      if (rd_pend_r) begin
        if (rd_map_r) begin
          reg_rdata <= mem_rdata;
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end
endmodule

// File: tb/sbid_boot_model.sv
`timescale 1ns/1ps
// boot sequencer stand-in: first run loads one byte, later runs answer nack
module sbid_boot_model (
  input  wire mclk,
  input  wire reset,
  output wire arb_start,
  output wire arb_lost,
  output wire wr,
  output wire nack,
  output wire done
);
  reg [4:0] cnt_r = 5'h00;
  reg       run2_r = 1'b0;
  always @(posedge mclk) begin
    if (reset) begin
      run2_r <= run2_r | (cnt_r != 5'h00);
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'h1F) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  assign arb_start = cnt_r == 5'h08;
  // one loss in the first run stays inside a limit of one; two in later runs use it up
  assign arb_lost = (cnt_r == 5'h0A) || (run2_r && cnt_r == 5'h0B);
  assign wr = !run2_r && cnt_r == 5'h0C;
  assign nack = run2_r && cnt_r == 5'h0C;
  assign done = !run2_r && cnt_r == 5'h0E;
endmodule

// File: tb/sbid_checker.sv
`timescale 1ns/1ps
module sbid_checker (
  input wire       mclk,
  input wire       reset,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [9:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_rvalid,
  input wire       boot_wr,
  input wire [9:0] boot_addr,
  input wire       boot_nack,
  input wire       boot_busy,
  input wire       boot_load_failure,
  input wire [4:0] arb_retry_limit,
  input wire       wide_offset_select,
  input wire [6:0] boot_rom_bus_address
);
  wire [4:0] wd_retry = reg_wdata[7:3];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RD_LAT:
    assert property (reg_rd && !boot_busy |-> ##2 reg_rvalid) else $error("read late");
  AST_BUSY_WR:
    assert property (reg_wr && boot_busy && !(boot_wr && boot_addr == 10'h001) |=>
      $stable(boot_rom_bus_address)) else $error("write taken while busy");
  AST_RETRY_RST:
    assert property ($fell(reset) |-> arb_retry_limit == 5'h01) else $error("retry reset");
  AST_BUSY_RST:
    assert property ($fell(reset) |-> boot_busy) else $error("not busy after reset");
  AST_BUSY_LOW:
    assert property (!boot_busy |=> !boot_busy) else $error("busy again");
  AST_RETRY_WR:
    assert property (reg_wr && !boot_busy && reg_addr == 10'h000 |=>
      arb_retry_limit == $past(wd_retry)) else $error("retry field");
  AST_ROM_WR:
    assert property (reg_wr && !boot_busy && reg_addr == 10'h001 |=>
      {wide_offset_select, boot_rom_bus_address} == $past(reg_wdata)) else $error("rom addr");
  AST_NACK_FAIL:
    assert property (boot_busy && boot_nack |-> ##[1:2] boot_load_failure) else $error("no fail");
  AST_FAIL_HOLD:
    assert property (boot_load_failure |=> boot_load_failure) else $error("fail dropped");
  cover property (reg_rd && !boot_busy);
  cover property (boot_busy && boot_nack);
  cover property (reg_wr && !boot_busy && reg_addr == 10'h001);
endmodule

// File: tb/sbid_top_tb.sv
`timescale 1ns/1ps
module sbid_top_tb;
  reg        mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  reg  [9:0] reg_addr = 10'h000;
  reg  [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [4:0] lim;
  wire [6:0] rom_a;
  wire       rvalid, ast, alo, bwr, bnk, bdn, busy, gup, fail, wide, otp, sro;
  integer    num_errors = 0, check_count = 0, i;
  always #20 mclk = ~mclk;
  sbid_top #(.ROM_DIS_RST(1'b0)) uut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(rvalid), .boot_wr(bwr), .boot_addr(10'h005), .boot_wdata(8'hA4),
    .boot_arb_start(ast), .boot_arb_lost(alo), .boot_nack(bnk), .boot_crc_bad(1'b0),
    .boot_done(bdn), .boot_busy(busy), .boot_give_up(gup), .boot_load_failure(fail),
    .arb_retry_limit(lim), .otp_load_disable_n(otp), .serial_rom_load_disable_n(sro),
    .wide_offset_select(wide), .boot_rom_bus_address(rom_a));
  sbid_boot_model u_mdl (.mclk(mclk), .reset(reset), .arb_start(ast), .arb_lost(alo),
    .wr(bwr), .nack(bnk), .done(bdn));
  task chk(input [7:0] got, input [7:0] exp); begin
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  // an idle edge after each write keeps the strobe from being set twice in one step
  task wr(input [9:0] a, input [7:0] d); begin
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge mclk);
    #1 reg_wr = 0;
    @(posedge mclk);
    #1;
  end endtask
  // the answer pulse stands for the cycle after the second edge that follows the request
  task rd(input [9:0] a, input [7:0] exp); begin
    reg_addr = a;
    reg_rd = 1;
    @(posedge mclk);
    #1 reg_rd = 0;
    @(posedge mclk);
    #1 chk(rvalid === 1'b1 ? reg_rdata : 8'hEE, exp);
  end endtask
  // the write lands during init and must be dropped
  task rst; begin
    reset = 1;
    repeat (8) @(posedge mclk);
    #1 reset = 0;
    wr(10'h001, 8'h11);
    i = 0;
    while (i < 200 && busy !== 1'b0) begin
      @(posedge mclk);
      #1 i = i + 1;
    end
    chk({7'h0, busy}, 8'h00);
  end endtask
  task report_and_stop; begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  initial begin #200000; num_errors = num_errors + 1; report_and_stop; end
  initial begin
    rst;
    chk({4'h0, gup, fail, otp, sro}, 8'h00);
    rd(10'h001, 8'h50);
    rd(10'h000, 8'h08);
    rd(10'h002, 8'h01);
    rd(10'h003, 8'h23);
    rd(10'h004, 8'h40);
    rd(10'h005, 8'hA4);
    $display("boot load test done");
    wr(10'h000, 8'hFA);
    rd(10'h000, 8'hFA);
    chk({3'h0, lim}, 8'h1F);
    chk({6'h0, otp, sro}, 8'h02);
    wr(10'h001, 8'hFF);
    rd(10'h001, 8'hFF);
    chk({wide, rom_a}, 8'hFF);
    wr(10'h004, 8'h0F);
    wr(10'h005, 8'hFE);
    rd(10'h004, 8'h0F);
    rd(10'h005, 8'hFE);
    rd(10'h006, 8'h00);
    $display("read write test done");
    rst;
    chk({4'h0, gup, fail, otp, sro}, 8'h0C);
    rd(10'h005, 8'h00);
    $display("boot failure test done");
    report_and_stop;
  end
endmodule
bind sbid_top sbid_checker u_chk (
  .mclk                 (mclk),
  .reset                (reset),
  .reg_wr               (reg_wr),
  .reg_rd               (reg_rd),
  .reg_addr             (reg_addr),
  .reg_wdata            (reg_wdata),
  .reg_rvalid           (reg_rvalid),
  .boot_wr              (boot_wr),
  .boot_addr            (boot_addr),
  .boot_nack            (boot_nack),
  .boot_busy            (boot_busy),
  .boot_load_failure    (boot_load_failure),
  .arb_retry_limit      (arb_retry_limit),
  .wide_offset_select   (wide_offset_select),
  .boot_rom_bus_address (boot_rom_bus_address)
);
